// *** tsm_device.sv ***
// Converter end: data margin checking, delay tuning, sync pulse logic and interrupt.
//
// Notes on behaviour
// - Margin samples before and after; mismatch flags error.
// - Four-bit data margin sets margin sample spacing.
// - Flag error when margin short, data maybe fine.
// - Error type bit: low hold, high setup.
// - Auto mode: setup raises delay, hold lowers it.
// - Applied delay code reads back to software.
// - Manual mode never alters the programmed delay.
// - Delay enable resets off; code applies once enabled.
// - Manual: one check per configuration; a changed delay code or data margin restarts.
// - Optimisation only when data timed to output clock.
// - Init pulse one cycle loads programmed clock state.
// - Thirty-two state machine; aligned reloads change nothing.
// - Sync ratio sets edges per pulse; 101-111 invalid.
// - Source gives sync edges every multiple of 32.
// - Clock state increment advances clocks one cycle.
// - Sync margin setting; short margin flags sync error.
// - One-shot or periodic sync, sampled on sample clock.
// - Interrupt is open-drain, active low, wired-OR capable.
// - Both flags interrupt by default; each maskable.
// - Flags latched until register read or overwritten.
// - Host recovery: lower margin, then step sync delay.
//
// The implementer's own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
module tsm_device #(
  parameter int DW = tsm_pkg::DATA_WIDTH
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  tsm_link_if.device link,
  output logic [DW-1:0] data_word_o,
  output logic data_valid_o,
  output logic [4:0] clock_state_o,
  output logic init_pulse_o,
  output logic [3:0] applied_delay_o
);
  import tsm_pkg::*;

  typedef struct packed {
    logic [DW-1:0] data_s1;
    logic [HIST_DEPTH-1:0][DW-1:0] dhist;
    logic sync_s1;
    logic [HIST_DEPTH-1:0] shist;
    logic [4:0] cstate;
    logic init;
    logic [4:0] edge_cnt;
    logic [15:0] dline;
    logic dclk;
    logic [7:0] ctrl;
    logic [7:0] margin;
    logic [2:0] ratio;
    logic [4:0] cstate_cfg;
    logic data_err;
    logic sync_err;
    logic err_type;
    logic dmask;
    logic smask;
    logic armed;
    logic [7:0] rdata;
    logic rvalid;
    logic [DW-1:0] dword;
    logic dvalid;
    logic irq;
  } state_s;

  state_s st_ff;
  state_s nxt_st;

  // One step of the delay code toward later or earlier, held at the ends.
  function automatic logic [3:0] step_delay(input logic [3:0] code, input logic up);
    logic [3:0] res;
    res = code;
    if (up && code != 4'hf) begin
      res = code + 4'h1;
    end else if (!up && code != 4'h0) begin
      res = code - 4'h1;
    end
    return res;
  endfunction : step_delay

  // True when the sync level is unsteady within the margin around a rising edge.
  function automatic logic sync_window_bad(input logic [HIST_DEPTH-1:0] h,
                                           input logic [3:0] m);
    logic bad;
    bad = 1'b0;
    for (int i = 1; i < 16; i++) begin
      if (i <= int'(m)) begin
        if (h[SAMPLE_POS+i] || !h[SAMPLE_POS-i]) begin
          bad = 1'b1;
        end
      end
    end
    return bad;
  endfunction : sync_window_bad

  logic tick;
  logic sync_edge;
  logic setup_bad;
  logic hold_bad;
  logic check_now;
  logic [3:0] dmargin;
  logic [4:0] ratio_target;

  // Next-state logic for the whole block.
  always_comb begin
    nxt_st = st_ff;
    dmargin = st_ff.margin[7:4];
    // Sample point is the clock-state phase where the data clock falls.
    tick = (st_ff.cstate[2:0] == 3'h0);
    // Two flops on the data and sync pins before any logic looks at them.
    nxt_st.data_s1 = link.data_bus;
    nxt_st.dhist = {st_ff.dhist[HIST_DEPTH-2:0], st_ff.data_s1};
    nxt_st.sync_s1 = link.sync_in;
    nxt_st.shist = {st_ff.shist[HIST_DEPTH-2:0], st_ff.sync_s1};

    // Earlier sample differing means data changed late; later one, early.
    setup_bad = (st_ff.dhist[SAMPLE_POS + int'(dmargin)] != st_ff.dhist[SAMPLE_POS]);
    hold_bad = (st_ff.dhist[SAMPLE_POS - int'(dmargin)] != st_ff.dhist[SAMPLE_POS]);

    // Checks run only while data is timed against the output clock.
    check_now = tick && !st_ff.ctrl[CTRL_REFSEL_BIT] &&
                (st_ff.ctrl[CTRL_AUTO_BIT] || st_ff.armed);
    nxt_st.dvalid = tick;
    if (tick) begin
      nxt_st.dword = st_ff.dhist[SAMPLE_POS];
    end
    if (check_now) begin
      nxt_st.armed = 1'b0;
    end

    // Clock generation: 32 states, reloaded by the init pulse.
    nxt_st.cstate = st_ff.init ? st_ff.cstate_cfg : st_ff.cstate + 5'h1;
    nxt_st.dline = {st_ff.dline[14:0], st_ff.cstate[DCLK_PHASE_BIT]};
    // Delay code stays out of the path until the enable bit is set.
    nxt_st.dclk = st_ff.ctrl[CTRL_DLYEN_BIT] ? st_ff.dline[st_ff.ctrl[3:0]] :
                  st_ff.dline[0];

    // Sync edge counting; invalid ratio codes never produce a pulse.
    sync_edge = st_ff.shist[SAMPLE_POS] && !st_ff.shist[SAMPLE_POS+1];
    ratio_target = 5'h1 << st_ff.ratio;
    nxt_st.init = 1'b0;
    if (sync_edge && st_ff.ratio <= RATIO_MAX) begin
      if (st_ff.edge_cnt + 5'h1 >= ratio_target) begin
        nxt_st.edge_cnt = 5'h0;
        nxt_st.init = 1'b1;
      end else begin
        nxt_st.edge_cnt = st_ff.edge_cnt + 5'h1;
      end
    end

    // Register port; reads answer one cycle later.
    nxt_st.rvalid = link.reg_rd;
    if (link.reg_rd) begin
      if (link.reg_addr == ADDR_CTRL) begin
        nxt_st.rdata = st_ff.ctrl;
      end else if (link.reg_addr == ADDR_MARGIN) begin
        nxt_st.rdata = st_ff.margin;
      end else if (link.reg_addr == ADDR_SYNC) begin
        nxt_st.rdata = {5'h00, st_ff.ratio};
      end else if (link.reg_addr == ADDR_CSTATE) begin
        nxt_st.rdata = {3'h0, st_ff.cstate_cfg};
      end else if (link.reg_addr == ADDR_IRQ) begin
        nxt_st.rdata = {st_ff.data_err, st_ff.sync_err, st_ff.err_type, 1'b0,
                        st_ff.dmask, st_ff.smask, 2'b00};
        nxt_st.data_err = 1'b0;
        nxt_st.sync_err = 1'b0;
      end else begin
        nxt_st.rdata = 8'h00;
      end
    end
    if (link.reg_wr) begin
      if (link.reg_addr == ADDR_CTRL) begin
        nxt_st.ctrl = link.reg_wdata;
        if (link.reg_wdata[3:0] != st_ff.ctrl[3:0]) begin
          nxt_st.armed = 1'b1;
        end
      end else if (link.reg_addr == ADDR_MARGIN) begin
        nxt_st.margin = link.reg_wdata;
        if (link.reg_wdata[7:4] != st_ff.margin[7:4]) begin
          nxt_st.armed = 1'b1;
        end
      end else if (link.reg_addr == ADDR_SYNC) begin
        nxt_st.ratio = link.reg_wdata[2:0];
      end else if (link.reg_addr == ADDR_CSTATE) begin
        nxt_st.cstate_cfg = link.reg_wdata[4:0];
      end else if (link.reg_addr == ADDR_IRQ) begin
        // Writing zero to a flag clears it; writing one leaves it as is.
        nxt_st.data_err = st_ff.data_err & link.reg_wdata[IRQ_DATA_BIT];
        nxt_st.sync_err = st_ff.sync_err & link.reg_wdata[IRQ_SYNC_BIT];
        nxt_st.dmask = link.reg_wdata[IRQ_DMASK_BIT];
        nxt_st.smask = link.reg_wdata[IRQ_SMASK_BIT];
      end
    end

    // Error events come last so that a set beats a clear in the same cycle.
    if (check_now && (setup_bad || hold_bad)) begin
      nxt_st.data_err = 1'b1;
      nxt_st.err_type = setup_bad;
      if (st_ff.ctrl[CTRL_AUTO_BIT]) begin
        // A write in the same cycle loses to the adjustment of the applied code.
        nxt_st.ctrl[3:0] = step_delay(st_ff.ctrl[3:0], setup_bad);
      end
    end
    if (sync_edge && sync_window_bad(st_ff.shist, st_ff.margin[3:0])) begin
      nxt_st.sync_err = 1'b1;
    end

    // Active-high request, pulled low on the pin through the enable.
    nxt_st.irq = (nxt_st.data_err && !nxt_st.dmask) ||
                 (nxt_st.sync_err && !nxt_st.smask);
  end

  // All state in one register; apart from register writes, the delay code only moves in auto mode.
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= '0;
      st_ff.ctrl <= CTRL_RST;
      st_ff.margin <= MARGIN_RST;
      st_ff.ratio <= RATIO_RST;
      st_ff.cstate_cfg <= CSTATE_RST;
      st_ff.armed <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign link.data_clock_out = st_ff.dclk;
  assign link.irq_n_out = 1'b0;
  assign link.irq_n_oe = st_ff.irq;
  assign link.reg_rdata = st_ff.rdata;
  assign link.reg_rvalid = st_ff.rvalid;
  assign data_word_o = st_ff.dword;
  assign data_valid_o = st_ff.dvalid;
  assign clock_state_o = st_ff.cstate;
  assign init_pulse_o = st_ff.init;
  assign applied_delay_o = st_ff.ctrl[CTRL_DLYEN_BIT] ? st_ff.ctrl[3:0] : 4'h0;
endmodule : tsm_device

// *** tsm_pkg.sv ***
// Shared constants for the input timing supervision block and its controller.
package tsm_pkg;
  // History depth and the position of the real sampling instant within it.
  localparam int HIST_DEPTH = 32;
  localparam int SAMPLE_POS = 16;
  localparam int DATA_WIDTH = 16;
  localparam int CLK_STATES = 32;
  // Clock-state bit that forms the output data clock (period of eight cycles).
  localparam int DCLK_PHASE_BIT = 2;
  // Device register addresses.
  localparam logic [4:0] ADDR_CTRL = 5'h03;
  localparam logic [4:0] ADDR_MARGIN = 5'h04;
  localparam logic [4:0] ADDR_SYNC = 5'h05;
  localparam logic [4:0] ADDR_CSTATE = 5'h06;
  localparam logic [4:0] ADDR_IRQ = 5'h19;
  // Control register fields; the delay code sits in bits 3:0.
  localparam int CTRL_AUTO_BIT = 7;
  localparam int CTRL_DLYEN_BIT = 6;
  localparam int CTRL_REFSEL_BIT = 5;
  // Interrupt register fields.
  localparam int IRQ_DATA_BIT = 7;
  localparam int IRQ_SYNC_BIT = 6;
  localparam int IRQ_TYPE_BIT = 5;
  localparam int IRQ_DMASK_BIT = 3;
  localparam int IRQ_SMASK_BIT = 2;
  // Reset values.
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MARGIN_RST = 8'h00;
  localparam logic [2:0] RATIO_RST = 3'h0;
  localparam logic [4:0] CSTATE_RST = 5'h00;
  localparam logic [2:0] RATIO_MAX = 3'h4;
  // Controller bus offsets and fields.
  localparam logic [7:0] HOST_CMD = 8'h00;
  localparam logic [7:0] HOST_STAT = 8'h04;
  localparam logic [7:0] HOST_DATA = 8'h08;
  localparam logic [7:0] HOST_SYNC = 8'h0c;
  localparam int CMD_RD_BIT = 13;
  localparam int STAT_BUSY_BIT = 8;
  localparam int STAT_IRQ_BIT = 9;
  localparam int SYNC_PER_BIT = 0;
  localparam int SYNC_ONE_BIT = 1;
  localparam int SYNC_INC_BIT = 2;
  localparam int SYNC_HIGH_CYCLES = 4;
endpackage : tsm_pkg

// *** tsm_link_if.sv ***
// Link between the converter timing monitor and its data source.
`timescale 1ns/10ps
interface tsm_link_if;
  import tsm_pkg::*;
  logic [DATA_WIDTH-1:0] data_bus;
  logic data_clock_out;
  logic sync_in;
  logic irq_n_out;
  logic irq_n_oe;
  logic irq_n;
  logic reg_wr;
  logic reg_rd;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  // Open-drain wire with its external pull-up.
  assign irq_n = irq_n_oe ? irq_n_out : 1'b1;
  modport device (input data_bus, sync_in, reg_wr, reg_rd, reg_addr, reg_wdata,
    output data_clock_out, irq_n_out, irq_n_oe, reg_rdata, reg_rvalid);
  modport host (output data_bus, sync_in, reg_wr, reg_rd, reg_addr, reg_wdata,
    input data_clock_out, irq_n, reg_rdata, reg_rvalid);
endinterface : tsm_link_if

// *** tsm_host.sv ***
// Data source end: AHB-Lite command registers, data launch, sync generation.
`timescale 1ns/10ps
module tsm_host (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  tsm_link_if.host link,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  import tsm_pkg::*;

  typedef struct packed {
    logic dp_wr;
    logic [7:0] dp_addr;
    logic [31:0] rdata;
    logic rd_pend;
    logic [7:0] last_rd;
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [7:0] wdata;
    logic [DATA_WIDTH-1:0] data;
    logic [7:0] sync_cfg;
    logic [9:0] sync_cnt;
    logic [2:0] high_cnt;
    logic sync;
    logic dclk_s1;
    logic dclk_s2;
    logic dclk_d;
    logic irq_s1;
    logic irq_s2;
  } state_s;

  state_s st_ff;
  state_s nxt_st;
  logic take;
  logic [9:0] period;

  // Bus decode, link commands, data launch and sync pulse generation.
  always_comb begin
    nxt_st = st_ff;
    take = hsel && hready && htrans[1];
    period = {st_ff.sync_cfg[7:4], 6'h00} >> 1;
    nxt_st.dp_wr = take && hwrite;
    nxt_st.wr = 1'b0;
    nxt_st.rd = 1'b0;
    if (take) begin
      nxt_st.dp_addr = haddr[7:0];
      if (haddr[7:0] == HOST_STAT) begin
        nxt_st.rdata = {22'h0, st_ff.irq_s2 == 1'b0, st_ff.rd_pend, st_ff.last_rd};
      end else if (haddr[7:0] == HOST_DATA) begin
        nxt_st.rdata = {16'h0, st_ff.data};
      end else if (haddr[7:0] == HOST_SYNC) begin
        nxt_st.rdata = {24'h0, st_ff.sync_cfg};
      end else begin
        nxt_st.rdata = 32'h0;
      end
    end
    if (st_ff.dp_wr) begin
      if (st_ff.dp_addr == HOST_CMD) begin
        nxt_st.rd = hwdata[CMD_RD_BIT];
        nxt_st.wr = !hwdata[CMD_RD_BIT];
        nxt_st.addr = hwdata[12:8];
        nxt_st.wdata = hwdata[7:0];
        nxt_st.rd_pend = hwdata[CMD_RD_BIT];
      end else if (st_ff.dp_addr == HOST_DATA) begin
        nxt_st.data = hwdata[DATA_WIDTH-1:0];
      end else if (st_ff.dp_addr == HOST_SYNC) begin
        nxt_st.sync_cfg = hwdata[7:0];
      end
    end
    if (link.reg_rvalid) begin
      nxt_st.last_rd = link.reg_rdata;
      nxt_st.rd_pend = 1'b0;
    end
    // The data clock and interrupt pins from the device pass two flops first.
    nxt_st.dclk_s1 = link.data_clock_out;
    nxt_st.dclk_s2 = st_ff.dclk_s1;
    nxt_st.dclk_d = st_ff.dclk_s2;
    nxt_st.irq_s1 = link.irq_n;
    nxt_st.irq_s2 = st_ff.irq_s1;
    // New word on each rising data clock edge when counting is on.
    if (st_ff.dclk_s2 && !st_ff.dclk_d && st_ff.sync_cfg[SYNC_INC_BIT]) begin
      nxt_st.data = st_ff.data + 16'h1;
    end
    // Periodic or one-shot sync; edges every 32 times the period field.
    nxt_st.sync = st_ff.high_cnt != 3'h0;
    if (st_ff.high_cnt != 3'h0) begin
      nxt_st.high_cnt = st_ff.high_cnt - 3'h1;
    end
    nxt_st.sync_cnt = st_ff.sync_cnt + 10'h1;
    if (st_ff.sync_cfg[SYNC_PER_BIT] && period != 10'h0 &&
        st_ff.sync_cnt + 10'h1 >= period) begin
      nxt_st.sync_cnt = 10'h0;
      nxt_st.high_cnt = 3'(SYNC_HIGH_CYCLES);
    end
    if (st_ff.dp_wr && st_ff.dp_addr == HOST_SYNC && hwdata[SYNC_ONE_BIT]) begin
      nxt_st.high_cnt = 3'(SYNC_HIGH_CYCLES);
      nxt_st.sync_cfg[SYNC_ONE_BIT] = 1'b0;
    end
  end

  // Single state register for the controller.
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= '0;
      st_ff.irq_s1 <= 1'b1;
      st_ff.irq_s2 <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_ff.rdata;
  assign link.data_bus = st_ff.data;
  assign link.sync_in = st_ff.sync;
  assign link.reg_wr = st_ff.wr;
  assign link.reg_rd = st_ff.rd;
  assign link.reg_addr = st_ff.addr;
  assign link.reg_wdata = st_ff.wdata;
endmodule : tsm_host

// *** tsm_link_properties.sv ***
// Concurrent checks on the link between the timing monitor and its data source.
`timescale 1ns/10ps
module tsm_link_properties
  import tsm_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic irq_n_out,
  input wire logic irq_n_oe,
  input wire logic irq_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);
  logic [7:0] ctl_ff;
  logic [7:0] mrg_ff;
  logic [1:0] msk_ff;
  logic [4:0] ra_ff;
  logic acc;
  // Shadows of what software last wrote, so readback can be judged without the bodies.
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctl_ff <= CTRL_RST;
      mrg_ff <= MARGIN_RST;
      msk_ff <= 2'h0;
      ra_ff <= 5'h00;
    end else begin
      if (reg_wr && reg_addr == ADDR_CTRL) ctl_ff <= reg_wdata;
      if (reg_wr && reg_addr == ADDR_MARGIN) mrg_ff <= reg_wdata;
      if (reg_wr && reg_addr == ADDR_IRQ) msk_ff <= {reg_wdata[3], reg_wdata[2]};
      if (reg_rd) ra_ff <= reg_addr;
    end
  end
  // Any touch of the interrupt register may legally drop the flags.
  assign acc = (reg_rd || reg_wr) && reg_addr == ADDR_IRQ;
  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("register read not answered");
  a_answer_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("answer without a read");
  a_irq_pulls_low: assert property (irq_n_oe |-> !irq_n_out && !irq_n)
    else $error("interrupt pin not pulled low");
  a_irq_pulled_up: assert property (!irq_n_oe |-> irq_n)
    else $error("released interrupt pin not high");
  a_ctrl_kept: assert property (reg_rvalid && ra_ff == ADDR_CTRL && !ctl_ff[7]
    |-> reg_rdata == ctl_ff)
    else $error("manual delay code altered");
  a_margin_kept: assert property (reg_rvalid && ra_ff == ADDR_MARGIN
    |-> reg_rdata == mrg_ff)
    else $error("margin readback wrong");
  a_masked_quiet: assert property (msk_ff == 2'h3 && $past(msk_ff) == 2'h3
    |-> !irq_n_oe)
    else $error("masked flags drive interrupt");
  a_flag_latched: assert property ($fell(irq_n_oe)
    |-> $past(acc) || $past(acc, 2) || $past(acc, 3))
    else $error("interrupt dropped on its own");
endmodule : tsm_link_properties

// *** input_timing_sync_monitor_tb.sv ***
// Bench joining both ends over the link, software reaching the source end over AHB-Lite.
`timescale 1ns/10ps
module input_timing_sync_monitor_tb;
  import tsm_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [15:0] data_word_o;
  logic data_valid_o;
  logic [4:0] clock_state_o;
  logic init_pulse_o;
  logic [3:0] applied_delay_o;
  logic rd_ph = 1'b0;
  logic [31:0] rnd = 32'h0debbd1a;
  logic [31:0] m;
  logic [4:0] s0;
  logic [4:0] s1;
  logic [31:0] val_q[$];
  logic [31:0] msk_q[$];
  logic [4:0] ra[6] = '{ADDR_CTRL, ADDR_MARGIN, ADDR_SYNC, ADDR_CSTATE, ADDR_IRQ, 5'h1f};
  logic [7:0] rv[6] = '{CTRL_RST, MARGIN_RST, {5'h0, RATIO_RST}, {3'h0, CSTATE_RST}, 8'h0, 8'h0};
  int fails = 0;
  int samples_checked = 0;
  int t;
  tsm_link_if link ();
  tsm_device i_tsm_device (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .link(link),
    .data_word_o(data_word_o), .data_valid_o(data_valid_o), .clock_state_o(clock_state_o),
    .init_pulse_o(init_pulse_o), .applied_delay_o(applied_delay_o));
  tsm_host i_tsm_host (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .link(link), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  tsm_link_properties i_tsm_link_properties (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .irq_n_out(link.irq_n_out), .irq_n_oe(link.irq_n_oe), .irq_n(link.irq_n),
    .reg_wr(link.reg_wr), .reg_rd(link.reg_rd), .reg_addr(link.reg_addr),
    .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata), .reg_rvalid(link.reg_rvalid));
  // Free-running 100 MHz clock.
  always #5 ref_clk_i = ~ref_clk_i;
  // Fixed seed, so every run drives the same words.
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : idle
  // Bounded wait for hready; a stuck slave ends the run.
  task automatic wait_ready();
    int k;
    k = 0;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      chk(32'h0, 32'h1);
      end_sim();
    end
  endtask : wait_ready
  // One single-word transfer; a read notes its expected word for the monitor.
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] mk);
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    if (!wr) begin
      val_q.push_back(d);
      msk_q.push_back(mk);
      rd_ph <= 1'b1;
    end
    wait_ready();
    rd_ph <= 1'b0;
  endtask : ahb
  // Device registers go through the command word; waits follow the fixed walk.
  task automatic dev_wr(input logic [4:0] a, input logic [7:0] d);
    ahb(1'b1, HOST_CMD, {18'h0, 1'b0, a, d}, 32'h0);
    idle(3);
  endtask : dev_wr
  task automatic dev_rd(input logic [4:0] a, input logic [7:0] x, input logic [7:0] mk);
    ahb(1'b1, HOST_CMD, {18'h0, 1'b1, a, 8'h00}, 32'h0);
    idle(4);
    ahb(1'b0, HOST_STAT, {24'h0, x}, {23'h0, 1'b1, mk});
  endtask : dev_rd
  task automatic wait_pulse();
    t = 0;
    do begin
      @(negedge ref_clk_i);
      t++;
    end while (init_pulse_o !== 1'b1 && t < 1200);
  endtask : wait_pulse
  // Spacing of reloads once the ratio counter has settled; the first gap is skipped.
  task automatic sync_gap(input logic [2:0] k, output logic [4:0] s);
    dev_wr(ADDR_SYNC, {5'h0, k});
    wait_pulse();
    wait_pulse();
    s = clock_state_o;
    @(negedge ref_clk_i);
    chk(init_pulse_o, 32'h0);
    wait_pulse();
    chk(t, k > RATIO_MAX ? 1200 : (32 << k) - 1);
    if (k <= RATIO_MAX) chk(clock_state_o, s);
    @(posedge ref_clk_i);
  endtask : sync_gap
  // Read data are taken at the edge that ends the data phase.
  always @(posedge ref_clk_i) begin
    if (rd_ph && hreadyout) begin
      m = msk_q.pop_front();
      chk(hrdata & m, val_q.pop_front() & m);
    end
  end
  initial begin
    idle(20);
    rstn_i <= 1'b1;
    idle(1);
    for (int i = 0; i < 6; i++) dev_rd(ra[i], rv[i], 8'hff);
    ahb(1'b0, 8'h10, 32'h0, 32'hffffffff);
    rnd = lfsr(rnd);
    ahb(1'b1, HOST_DATA, {16'h0, rnd[15:0]}, 32'h0);
    dev_wr(ADDR_MARGIN, 8'hf0);
    idle(100);
    @(negedge ref_clk_i);
    chk(data_word_o, rnd[15:0]);
    // One sample strobe per data clock period of eight cycles.
    s0 = 5'h0;
    repeat (8) begin
      @(negedge ref_clk_i);
      s0 = s0 + 5'(data_valid_o);
    end
    chk(s0, 32'h1);
    @(posedge ref_clk_i);
    // The word moved inside the margin window, so a hold error is latched although it is right.
    dev_rd(ADDR_IRQ, 8'h80, 8'ha0);
    ahb(1'b1, HOST_SYNC, 32'h4, 32'h0);
    // Let the counting words fill the history, so both margin samples differ at the check.
    idle(40);
    dev_wr(ADDR_MARGIN, 8'he0);
    idle(100);
    ahb(1'b0, HOST_STAT, 32'h200, 32'h200);
    dev_rd(ADDR_IRQ, 8'ha0, 8'ha0);
    idle(100);
    dev_rd(ADDR_IRQ, 8'h00, 8'h80);
    dev_wr(ADDR_CTRL, 8'h07);
    idle(100);
    dev_rd(ADDR_CTRL, 8'h07, 8'hff);
    dev_rd(ADDR_IRQ, 8'h80, 8'h80);
    @(negedge ref_clk_i);
    chk(applied_delay_o, 32'h0);
    @(posedge ref_clk_i);
    dev_wr(ADDR_CTRL, 8'h47);
    @(negedge ref_clk_i);
    chk(applied_delay_o, 32'h7);
    @(posedge ref_clk_i);
    dev_wr(ADDR_MARGIN, 8'hf0);
    idle(100);
    dev_wr(ADDR_IRQ, 8'h8c);
    idle(10);
    ahb(1'b0, HOST_STAT, 32'h0, 32'h200);
    dev_wr(ADDR_IRQ, 8'h80);
    idle(10);
    ahb(1'b0, HOST_STAT, 32'h200, 32'h200);
    dev_wr(ADDR_IRQ, 8'h00);
    idle(10);
    ahb(1'b0, HOST_STAT, 32'h0, 32'h200);
    dev_wr(ADDR_CTRL, 8'he0);
    idle(300);
    dev_rd(ADDR_CTRL, 8'he0, 8'hff);
    dev_wr(ADDR_CTRL, 8'hc0);
    idle(600);
    dev_rd(ADDR_CTRL, 8'hcf, 8'hff);
    @(negedge ref_clk_i);
    chk(applied_delay_o, 32'hf);
    @(posedge ref_clk_i);
    dev_wr(ADDR_MARGIN, 8'h00);
    idle(50);
    dev_wr(ADDR_CTRL, 8'h00);
    ahb(1'b1, HOST_SYNC, 32'h11, 32'h0);
    dev_wr(ADDR_MARGIN, 8'h02);
    idle(200);
    dev_rd(ADDR_IRQ, 8'h00, 8'h40);
    dev_wr(ADDR_MARGIN, 8'h08);
    idle(200);
    dev_rd(ADDR_IRQ, 8'h40, 8'h40);
    // Recovery: a smaller sync margin keeps the flag clear once it is read away.
    dev_wr(ADDR_MARGIN, 8'h02);
    dev_rd(ADDR_IRQ, 8'h00, 8'h00);
    idle(100);
    dev_rd(ADDR_IRQ, 8'h00, 8'h40);
    rnd = lfsr(rnd);
    dev_wr(ADDR_CSTATE, {3'h0, rnd[4:0]});
    sync_gap(3'h0, s0);
    dev_wr(ADDR_CSTATE, {3'h0, rnd[4:0] + 5'h1});
    sync_gap(3'h0, s1);
    s0 = s0 + 5'h1;
    chk(s1, s0);
    for (int k = 1; k < 8; k++) sync_gap(3'(k), s1);
    dev_wr(ADDR_SYNC, 8'h00);
    ahb(1'b1, HOST_SYNC, 32'h0, 32'h0);
    idle(100);
    ahb(1'b1, HOST_SYNC, 32'h2, 32'h0);
    wait_pulse();
    chk(t < 1200, 32'h1);
    wait_pulse();
    chk(t, 32'd1200);
    chk(hresp, 32'h0);
    end_sim();
  end
endmodule : input_timing_sync_monitor_tb
